// ===== hdl/rst_seq.sv
`timescale 1ns/10ps
// How it works
// R1 - Power-on or low-voltage reset: clocks off 4096 cycles, pin low, then start.
// R2 - Stop wake-up: counter times recovery, clocks off until delay expires.
// R3 - Wait mode stops CPU clock; peripheral clocks keep running.
// R4 - Every source asserts internal reset and picks vector; monitor uses alternate.
// R5 - Internal resets clear the stabilisation counter; pin reset leaves it.
// R6 - Each reset sets its own cause flag; low voltage taken outside run, wait or pin states sets none.
// R7 - Pin low halts; pin flag needs 67 cycles low, 4163 after power reset.
// R8 - Internal reset drives pin 32 cycles, then holds internal reset 32 more.
// R9 - Power-on: after 4096-cycle count, wait 64 more before releasing CPU.
// R10 - Power-on sets power flag and clears all other flags.
// R11 - Power-on enables generated clock and asserts internal reset.
// R12 - Watchdog overflow resets and flags when watchdog not disabled.
// R13 - Watchdog request accepted regardless of bus clock phase.
// R14 - Illegal instruction decode sets bad opcode flag and resets.
// R15 - Stop with halt permit zero is an illegal opcode reset.
// R16 - Only opcode fetch from unmapped address sets flag and resets.
// R17 - Low voltage resets when enabled; pin low 4096 after recovery, release 64 later.
// R18 - Counter is 12 bits, advancing on reference clock falling edge.
// R19 - Counter overflow clocks the watchdog.
// R20 - Stop clears counter; wake recovery 32 if short option, else 4096.
// R21 - Counter runs freely after any reset sequence.
// R22 - Latched interrupt holds until serviced, mask cleared or internal reset.
// R23 - Bus clock is generated clock output divided by two.
module rst_seq (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic osc_reference_clock,
  input wire logic power_on_pulse,
  input wire logic low_voltage_source,
  input wire logic watchdog_overflow,
  input wire logic watchdog_disable,
  input wire logic low_voltage_power_off,
  input wire logic low_voltage_reset_disable,
  input wire logic halt_permit,
  input wire logic short_recovery_option,
  input wire logic monitor_mode,
  input wire logic illegal_decode,
  input wire logic stop_exec,
  input wire logic wait_exec,
  input wire logic opcode_fetch,
  input wire logic addr_unmapped,
  input wire logic wake_event,
  input wire logic reset_pin_in,
  input wire logic [31:0] irq_req,
  input wire logic irq_start,
  input wire logic irq_serviced,
  input wire logic irq_mask,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic internal_reset,
  output logic [15:0] reset_vector,
  output logic [7:0] reset_cause_register,
  output logic generated_clock_output,
  output logic bus_clock,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic watchdog_tick,
  output logic [11:0] stab_count,
  output logic irq_valid,
  output logic [4:0] irq_index
);
  typedef enum logic [2:0] {
    ST_PWR = 3'b000,
    ST_DRIVE = 3'b001,
    ST_HOLD = 3'b010,
    ST_RUN = 3'b011,
    ST_WAIT = 3'b100,
    ST_STOP = 3'b101,
    ST_RECOV = 3'b110,
    ST_PIN = 3'b111
  } seq_state_e;

  seq_state_e state_ff;
  seq_state_e nxt_state;
  logic ref_q_ff;
  logic ref_fall;
  logic [11:0] cnt;
  logic wd_tick;
  logic [12:0] tick_ff;
  logic [12:0] pin_low_ff;
  logic power_seq_ff;
  logic short_rec_ff;
  logic gen_en_ff;
  logic div_ff;
  logic cnt_clear;
  logic wd_req;
  logic badop_req;
  logic badadr_req;
  logic lowv_req;
  logic int_req;
  logic pin_flag_set;
  logic [12:0] pin_need;

  // The reference clock is sampled; a falling edge becomes a one-cycle strobe.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ref_q_ff <= 1'b0;
    end else begin
      ref_q_ff <= osc_reference_clock;
    end
  end
  assign ref_fall = ref_q_ff && !osc_reference_clock; // R18

  // The watchdog request is a level from another clock tree, so it is taken
  // in any cycle rather than waiting for a bus-clock phase.
  assign wd_req = watchdog_overflow && !watchdog_disable; // R12 R13
  assign badop_req = illegal_decode || (stop_exec && !halt_permit); // R14 R15
  assign badadr_req = opcode_fetch && addr_unmapped; // R16
  assign lowv_req = low_voltage_source && !low_voltage_power_off &&
                    !low_voltage_reset_disable; // R17
  assign int_req = wd_req || badop_req || badadr_req;

  // Power and low-voltage reset clear the counter too; a pin reset does not.
  assign cnt_clear = power_on_pulse || lowv_req ||
                     ((state_ff == ST_RUN || state_ff == ST_WAIT) &&
                      int_req) ||
                     (state_ff == ST_RUN && stop_exec && halt_permit) ||
                     (state_ff == ST_STOP) ||
                     (state_ff == ST_PWR && low_voltage_source); // R5 R20

  stab_counter u_cnt (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .ref_fall(ref_fall),
    .clear(cnt_clear),
    .count_ff(cnt),
    .wdog_tick_ff(wd_tick)
  );

  assign pin_need = power_seq_ff ? 13'(rst_seq_pkg::PIN_MIN_POR_CYC) :
                                   13'(rst_seq_pkg::PIN_MIN_CYC); // R7

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_PWR: begin
        if (!power_on_pulse && !low_voltage_source &&
            tick_ff == 13'(rst_seq_pkg::LONG_REC_CYC - 1) && ref_fall) begin
          nxt_state = ST_HOLD; // R1 R9 R17
        end
      end
      ST_DRIVE: begin
        if (ref_fall && tick_ff == 13'(rst_seq_pkg::PIN_DRIVE_CYC - 1)) begin
          nxt_state = ST_HOLD; // R8
        end
      end
      ST_HOLD: begin
        if (!reset_pin_in) begin
          nxt_state = ST_PIN;
        end else if (ref_fall && tick_ff == 13'(power_seq_ff ?
                     rst_seq_pkg::RELEASE_CYC - 1 :
                     rst_seq_pkg::INTERNAL_RESET_EXTRA_CYC - 1)) begin
          nxt_state = ST_RUN; // R8 R9
        end
      end
      ST_RUN: begin
        if (int_req) begin
          nxt_state = ST_DRIVE;
        end else if (stop_exec && halt_permit) begin
          nxt_state = ST_STOP; // R20
        end else if (wait_exec) begin
          nxt_state = ST_WAIT; // R3
        end
      end
      ST_WAIT: begin
        if (int_req) begin
          nxt_state = ST_DRIVE;
        end else if (wake_event) begin
          nxt_state = ST_RUN;
        end
      end
      ST_STOP: begin
        if (wake_event || !reset_pin_in) begin
          nxt_state = ST_RECOV; // R2
        end
      end
      ST_RECOV: begin
        if (ref_fall && cnt == 12'((short_rec_ff ?
            rst_seq_pkg::SHORT_REC_CYC : rst_seq_pkg::LONG_REC_CYC) - 1)) begin
          nxt_state = reset_pin_in ? ST_RUN : ST_PIN; // R2 R20
        end
      end
      ST_PIN: begin
        if (reset_pin_in) begin
          nxt_state = ST_HOLD;
        end
      end
      default: nxt_state = ST_PWR;
    endcase
    if (state_ff != ST_STOP && state_ff != ST_RECOV && state_ff != ST_PIN &&
        !reset_pin_in && state_ff != ST_PWR && state_ff != ST_DRIVE) begin
      nxt_state = ST_PIN; // R7
    end
    if (power_on_pulse || lowv_req) begin
      nxt_state = ST_PWR; // R1 R17
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_PWR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Reference-cycle timer for the reset phases; restarts on every state change.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tick_ff <= 13'h0000;
    end else if (nxt_state != state_ff ||
                 (state_ff == ST_PWR && (power_on_pulse ||
                  low_voltage_source))) begin
      tick_ff <= 13'h0000; // R17
    end else if (ref_fall) begin
      tick_ff <= tick_ff + 13'h0001;
    end
  end

  // Counts how long the pin has been low, saturating at the longer limit.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_low_ff <= 13'h0000;
    end else if (reset_pin_in || reset_pin_oe) begin
      pin_low_ff <= 13'h0000;
    end else if (ref_fall &&
                 pin_low_ff != 13'(rst_seq_pkg::PIN_MIN_POR_CYC)) begin
      pin_low_ff <= pin_low_ff + 13'h0001;
    end
  end
  assign pin_flag_set = !reset_pin_in && !reset_pin_oe &&
                        pin_low_ff >= pin_need; // R7

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      power_seq_ff <= 1'b1;
    end else if (power_on_pulse || lowv_req) begin
      power_seq_ff <= 1'b1;
    end else if (state_ff == ST_RUN) begin
      power_seq_ff <= 1'b0;
    end
  end

  // The recovery choice is sampled at wake-up, not at stop entry.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      short_rec_ff <= 1'b0;
    end else if (state_ff == ST_STOP) begin
      short_rec_ff <= short_recovery_option; // R20
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reset_cause_register <= rst_seq_pkg::CAUSE_RESET;
    end else if (power_on_pulse) begin
      reset_cause_register <= rst_seq_pkg::CAUSE_RESET; // R10
    end else if (state_ff == ST_RUN || state_ff == ST_WAIT ||
                 state_ff == ST_PIN || state_ff == ST_PWR) begin
      if (lowv_req && state_ff != ST_PWR) begin
        reset_cause_register <= 8'h00;
        reset_cause_register[rst_seq_pkg::F_LOWV] <= 1'b1; // R6 R17
      end else if (state_ff != ST_PIN && state_ff != ST_PWR && int_req) begin
        reset_cause_register <= 8'h00;
        reset_cause_register[rst_seq_pkg::F_WDOG] <= wd_req; // R6 R12
        reset_cause_register[rst_seq_pkg::F_BADOP] <= badop_req; // R14
        reset_cause_register[rst_seq_pkg::F_BADADR] <= badadr_req; // R16
      end else if (pin_flag_set &&
                   !reset_cause_register[rst_seq_pkg::F_PIN]) begin
        reset_cause_register <= 8'h00;
        reset_cause_register[rst_seq_pkg::F_PIN] <= 1'b1; // R6 R7
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gen_en_ff <= 1'b1;
    end else begin
      gen_en_ff <= (nxt_state != ST_STOP); // R11
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_ff <= 1'b0;
    end else if (gen_en_ff) begin
      div_ff <= !div_ff; // R23
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reset_vector <= rst_seq_pkg::VEC_USER;
    end else begin
      reset_vector <= monitor_mode ? rst_seq_pkg::VEC_MON :
                                     rst_seq_pkg::VEC_USER; // R4
    end
  end

  assign generated_clock_output = gen_en_ff && clk_sys;
  assign bus_clock = div_ff;
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = (state_ff == ST_PWR) || (state_ff == ST_DRIVE); // R1 R8
  assign internal_reset = (state_ff == ST_PWR) || (state_ff == ST_DRIVE) ||
                          (state_ff == ST_HOLD) ||
                          (state_ff == ST_PIN); // R4 R11
  assign cpu_clk_en = (state_ff == ST_RUN); // R1 R2 R3
  assign periph_clk_en = (state_ff == ST_RUN) || (state_ff == ST_WAIT) ||
                         (state_ff == ST_HOLD); // R3
  assign watchdog_tick = wd_tick; // R19
  assign stab_count = cnt;

  irq_latch u_irq (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_reset(internal_reset),
    .irq_req(irq_req),
    .irq_start(irq_start),
    .irq_serviced(irq_serviced),
    .irq_mask(irq_mask),
    .irq_valid_ff(irq_valid),
    .irq_index_ff(irq_index)
  );
endmodule : rst_seq

// ===== hdl/rst_seq_pkg.sv
package rst_seq_pkg;
  localparam int CNT_W = 12;
  localparam logic [11:0] CNT_RESET = 12'h000;
  localparam int LONG_REC_CYC = 4096;
  localparam int SHORT_REC_CYC = 32;
  localparam int PIN_DRIVE_CYC = 32;
  localparam int INTERNAL_RESET_EXTRA_CYC = 32;
  localparam int RELEASE_CYC = 64;
  localparam int PIN_MIN_CYC = 67;
  localparam int PIN_MIN_POR_CYC = 4163;
  localparam int PIN_W = 13;
  localparam logic [15:0] VEC_USER = 16'hfffe;
  localparam logic [15:0] VEC_MON = 16'hfefe;
  // Cause flag positions in the reset cause register.
  localparam int F_POR = 7;
  localparam int F_PIN = 6;
  localparam int F_WDOG = 5;
  localparam int F_BADOP = 4;
  localparam int F_BADADR = 3;
  localparam int F_LOWV = 1;
  localparam logic [7:0] CAUSE_RESET = 8'h80;
  localparam int IRQ_N = 32;
  localparam int IRQ_IDX_W = 5;
endpackage : rst_seq_pkg

// ===== hdl/stab_counter.sv
`timescale 1ns/10ps
// Twelve-bit stabilisation counter; its wrap supplies the watchdog tick.
module stab_counter (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic ref_fall,
  input wire logic clear,
  output logic [11:0] count_ff,
  output logic wdog_tick_ff
);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count_ff <= rst_seq_pkg::CNT_RESET;
    end else if (clear) begin
      count_ff <= rst_seq_pkg::CNT_RESET; // R5
    end else if (ref_fall) begin
      count_ff <= count_ff + 12'h001; // R18 R21
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wdog_tick_ff <= 1'b0;
    end else begin
      wdog_tick_ff <= ref_fall && !clear && (count_ff == 12'hfff); // R19
    end
  end
endmodule : stab_counter

// ===== hdl/irq_latch.sv
`timescale 1ns/10ps
// Holds the winning interrupt until serviced, the mask is cleared or internal reset asserts.
module irq_latch (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic in_reset,
  input wire logic [31:0] irq_req,
  input wire logic irq_start,
  input wire logic irq_serviced,
  input wire logic irq_mask,
  output logic irq_valid_ff,
  output logic [4:0] irq_index_ff
);
  function automatic logic [4:0] pick(input logic [31:0] req);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (req[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction : pick

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_valid_ff <= 1'b0;
      irq_index_ff <= 5'h00;
    end else if (in_reset) begin
      irq_valid_ff <= 1'b0;
    end else if (irq_valid_ff) begin
      if (irq_serviced || !irq_mask) begin
        irq_valid_ff <= 1'b0; // R22
      end
    end else if (irq_start && (irq_req != 32'h00000000)) begin
      irq_valid_ff <= 1'b1; // R22
      irq_index_ff <= pick(irq_req);
    end
  end
endmodule : irq_latch

// ===== test/rst_seq_props.sv
`timescale 1ns/10ps
module rst_seq_props (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic monitor_mode,
  input wire logic illegal_decode,
  input wire logic watchdog_overflow,
  input wire logic watchdog_disable,
  input wire logic halt_permit,
  input wire logic stop_exec,
  input wire logic wait_exec,
  input wire logic opcode_fetch,
  input wire logic addr_unmapped,
  input wire logic irq_serviced,
  input wire logic irq_mask,
  input wire logic reset_pin_oe,
  input wire logic internal_reset,
  input wire logic [15:0] reset_vector,
  input wire logic [7:0] reset_cause_register,
  input wire logic cpu_clk_en,
  input wire logic watchdog_tick,
  input wire logic [11:0] stab_count,
  input wire logic irq_valid,
  input wire logic [4:0] irq_index
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Causes are checked only while the CPU runs; wait mode also takes them, unchecked.
  wire run = cpu_clk_en && !internal_reset;
  AST_PIN_IN_RST: assert property (reset_pin_oe |-> internal_reset)
    else $error("Pin driven outside reset.");
  AST_INTERNAL_RESET_TAIL: assert property ($fell(reset_pin_oe) |-> internal_reset [*8])
    else $error("Internal reset dropped with the pin.");
  AST_CPU_HELD: assert property (internal_reset |-> !cpu_clk_en)
    else $error("CPU clock on during reset.");
  AST_VECTOR: assert property (internal_reset && $past(internal_reset)
    && $stable(monitor_mode) |-> reset_vector == (monitor_mode ?
    rst_seq_pkg::VEC_MON : rst_seq_pkg::VEC_USER))
    else $error("Wrong reset vector.");
  AST_BAD_OPCODE: assert property (illegal_decode && run |=>
    reset_cause_register[rst_seq_pkg::F_BADOP] && reset_pin_oe)
    else $error("Illegal opcode not taken.");
  AST_BAD_FETCH: assert property (opcode_fetch && addr_unmapped && run
    |=> reset_cause_register[rst_seq_pkg::F_BADADR])
    else $error("Bad fetch not flagged.");
  AST_WDOG: assert property (watchdog_overflow && !watchdog_disable && run
    |=> reset_cause_register[rst_seq_pkg::F_WDOG])
    else $error("Watchdog reset not flagged.");
  AST_STOP_ILLEGAL: assert property (stop_exec && !halt_permit && run |=>
    reset_cause_register[rst_seq_pkg::F_BADOP] && internal_reset)
    else $error("Forbidden stop not reset.");
  AST_WAIT_CPU: assert property (wait_exec && run |=> !cpu_clk_en)
    else $error("CPU clock runs in wait.");
  AST_TICK_WRAP: assert property (watchdog_tick |-> stab_count == 12'h000)
    else $error("Watchdog tick without wrap.");
  AST_IRQ_HOLD: assert property (irq_valid && irq_mask && !irq_serviced
    && !internal_reset |=> irq_valid && $stable(irq_index))
    else $error("Latched interrupt displaced.");
  cover property ($fell(reset_pin_oe));
  cover property (wait_exec && run);
  cover property (irq_valid && irq_mask);
endmodule : rst_seq_props

bind rst_seq rst_seq_props rst_seq_props_inst (.clk_sys, .resetn,
  .monitor_mode, .illegal_decode, .watchdog_overflow, .watchdog_disable,
  .halt_permit, .stop_exec, .wait_exec, .opcode_fetch, .addr_unmapped,
  .irq_serviced, .irq_mask, .reset_pin_oe, .internal_reset, .reset_vector,
  .reset_cause_register, .cpu_clk_en, .watchdog_tick, .stab_count,
  .irq_valid, .irq_index);

// ===== test/board_peer.sv
`timescale 1ns/10ps
// Board peer on the open-drain reset line; a pull-up wins when nobody pulls.
module board_peer (
  input wire logic hold_low,
  input wire logic reset_pin_oe,
  output logic reset_pin_level
);
  assign reset_pin_level = !(hold_low || reset_pin_oe);
endmodule : board_peer

// ===== test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk_sys, resetn, power_on_pulse, low_voltage_source, hold_low;
  logic watchdog_disable, halt_permit, short_recovery_option, monitor_mode;
  logic wait_exec, wake_event, addr_unmapped, irq_start, irq_serviced;
  logic irq_mask, reset_pin_oe, reset_pin_level, internal_reset, prev_internal_reset;
  logic cpu_clk_en, periph_clk_en, irq_valid;
  logic bus_clock, gen_clk, bclk_prev;
  logic [1:0] rdiv;
  logic [3:0] cause_in;
  logic [31:0] irq_req;
  logic [4:0] irq_index, exp_idx;
  logic [15:0] reset_vector;
  logic [7:0] reset_cause_register;
  logic [11:0] stab_count;
  logic [7:0] cause_q[$];
  localparam logic [7:0] EXP_CAUSE[4] = '{8'h10, 8'h20, 8'h10, 8'h08};
  int error_cnt, comparisons, seed, n;
  rst_seq rst_seq_inst (.clk_sys, .resetn, .osc_reference_clock(rdiv[1]),
    .power_on_pulse, .low_voltage_source, .watchdog_overflow(cause_in[1]),
    .watchdog_disable, .low_voltage_power_off(1'b0),
    .low_voltage_reset_disable(1'b0), .halt_permit, .short_recovery_option,
    .monitor_mode, .illegal_decode(cause_in[0]), .stop_exec(cause_in[2]),
    .wait_exec, .opcode_fetch(cause_in[3]), .addr_unmapped, .wake_event,
    .reset_pin_in(reset_pin_level), .irq_req, .irq_start, .irq_serviced,
    .irq_mask, .reset_pin_out(), .reset_pin_oe, .internal_reset,
    .reset_vector, .reset_cause_register, .generated_clock_output(gen_clk),
    .bus_clock, .cpu_clk_en, .periph_clk_en, .watchdog_tick(),
    .stab_count, .irq_valid, .irq_index);
  board_peer board_peer_inst (.hold_low, .reset_pin_oe, .reset_pin_level);
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Reference clock is a quarter of the system clock: one fall per 4 cycles.
  always @(posedge clk_sys) rdiv <= rdiv + 2'h1;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : tick
  task automatic wait_run();
    n = 0;
    while (!(cpu_clk_en === 1'b1 && internal_reset === 1'b0)) begin
      @(negedge clk_sys);
      n++;
      if (n > 40000) begin
        error_cnt++;
        conclude();
      end
    end
    @(posedge clk_sys);
  endtask : wait_run
  task automatic wake();
    wake_event <= 1'b1;
    tick(1);
    wake_event <= 1'b0;
    wait_run();
  endtask : wake
  // The cause flags are judged once the sequence lets go of internal reset.
  always @(negedge clk_sys) begin
    if (prev_internal_reset === 1'b1 && internal_reset === 1'b0 && cause_q.size() > 0)
      chk(reset_cause_register, cause_q.pop_front());
    prev_internal_reset <= internal_reset;
  end
  initial begin
    seed = 30;
    {resetn, rdiv, cause_in, hold_low, wait_exec, wake_event} = '0;
    {watchdog_disable, halt_permit, short_recovery_option} = '0;
    {monitor_mode, low_voltage_source, addr_unmapped} = '0;
    {irq_start, irq_serviced, prev_internal_reset} = '0;
    power_on_pulse = 1'b1;
    irq_mask = 1'b1;
    irq_req = '0;
    tick(12);
    resetn <= 1'b1;
    tick(4);
    #1;
    chk({reset_pin_oe, internal_reset, cpu_clk_en}, 3'b110);
    tick(1);
    power_on_pulse <= 1'b0;
    cause_q.push_back(8'h80);
    wait_run();
    chk(n >= 16620 && n <= 16680, 1);
    addr_unmapped <= 1'b1;
    tick(8);
    #1;
    chk(internal_reset, 0);
    tick(1);
    for (int i = 0; i < 4; i++) begin
      monitor_mode <= 1'($random(seed));
      cause_in <= 4'h1 << i;
      cause_q.push_back(EXP_CAUSE[i]);
      tick(1);
      cause_in <= 4'h0;
      tick(2);
      #1;
      chk(stab_count <= 12'h001, 1);
      chk(reset_vector, monitor_mode ? rst_seq_pkg::VEC_MON :
        rst_seq_pkg::VEC_USER);
      wait_run();
      chk(n >= 240 && n <= 262, 1);
    end
    hold_low <= 1'b1;
    cause_q.push_back(8'h40);
    tick(320);
    hold_low <= 1'b0;
    wait_run();
    halt_permit <= 1'b1;
    short_recovery_option <= 1'b1;
    cause_in <= 4'h4;
    tick(1);
    cause_in <= 4'h0;
    tick(3);
    #1;
    chk({cpu_clk_en, periph_clk_en, stab_count}, 14'h0);
    chk(gen_clk, 0);
    tick(20);
    wake();
    chk(n >= 118 && n <= 136, 1);
    wait_exec <= 1'b1;
    tick(1);
    wait_exec <= 1'b0;
    tick(2);
    #1;
    chk({cpu_clk_en, periph_clk_en}, 2'b01);
    bclk_prev = bus_clock;
    tick(1);
    #1;
    chk(bus_clock, !bclk_prev);
    chk(gen_clk, 1);
    wake();
    watchdog_disable <= 1'b1;
    cause_in <= 4'h2;
    tick(1);
    cause_in <= 4'h0;
    tick(2);
    #1;
    chk(internal_reset, 0);
    tick(1);
    low_voltage_source <= 1'b1;
    cause_q.push_back(8'h02);
    tick(10);
    low_voltage_source <= 1'b0;
    wait_run();
    chk(n >= 16620 && n <= 16690, 1);
    irq_req <= ($random(seed) & 32'hfffffffe) | 32'h80000000;
    tick(1);
    for (int b = 31; b >= 0; b--) if (irq_req[b]) exp_idx = 5'(b);
    irq_start <= 1'b1;
    tick(1);
    irq_start <= 1'b0;
    irq_req <= irq_req | 32'h1;
    tick(3);
    #1;
    chk({irq_valid, irq_index}, {1'b1, exp_idx});
    tick(1);
    irq_serviced <= 1'b1;
    tick(1);
    irq_serviced <= 1'b0;
    tick(2);
    #1;
    chk(irq_valid, 0);
    conclude();
  end
endmodule : tb_top
